//--- scs_regs.sv
// System configuration and status special-register bank.
// Assumes an 8-bit register port on the core clock: one-cycle write
// strobe with address and data, and a read strobe answered one cycle
// later on rdata. PHY status and boot-side flags come from outside.
`timescale 1ns/1ns
`include "scs_regs_map.svh"

module scs_regs (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  addr,
  input  wire logic        wr_en,
  input  wire logic [7:0]  wdata,
  input  wire logic        rd_en,
  output logic [7:0]       rdata,
  input  wire logic        phy_duplex_half,
  input  wire logic        phy_rate_10m,
  input  wire logic        phy_link_up,
  input  wire logic [2:0]  mode_strap_pins,
  input  wire logic        flash_busy_in,
  input  wire logic        boot_running_in,
  input  wire logic [15:0] loader_target,
  output logic             phy_reset_out,
  output logic             phy_power_down,
  output logic [2:0]       phy_opmode,
  output logic             reboot_after_load,
  output logic             loader_enable,
  output logic [2:0]       offchip_store_mode,
  output logic             entry_access_en,
  output logic [7:0]       stretch_cfg_backup,
  output logic [7:0]       ptr_ext0_backup,
  output logic [7:0]       ptr_ext1_backup,
  output logic [7:0]       ptr_select_backup,
  output logic [15:0]      ram_base_reg,
  output logic [15:0]      ram_end_reg,
  output logic [7:0]       loader_ident_reg,
  output logic [15:0]      loader_addr_reg,
  output logic [7:0]       loader_data_reg
);

  scs_pkg::scs_state_t st_q;
  scs_pkg::scs_state_t st_d;
  scs_pkg::scs_sync_t  sy_q;
  scs_pkg::scs_sync_t  sy_d;
  logic [2:0]          duplex_s1_q;
  logic [2:0]          duplex_s2_q;
  logic [2:0]          strap_s1_q;
  logic [2:0]          strap_s2_q;
  logic [31:0]         cycle_counter;
  logic [7:0]          phy_state_reg;
  logic [7:0]          chip_config_reg;
  logic                flash_busy_flag;
  logic                boot_active_flag;

  // ----------------------------------------------------------------
  // Cycle counter
  // ----------------------------------------------------------------
  scs_cycle_counter u_cnt (
    .clk     (clk),
    .sys_rst (sys_rst),
    .count   (cycle_counter)
  );

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // PHY status, strap pins and loader flags arrive from other
  // domains or pads, so each passes two flops before use. The first
  // stage feeds only the second stage.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      duplex_s1_q <= `SCS_ZERO3;
      duplex_s2_q <= `SCS_ZERO3;
      strap_s1_q  <= `SCS_ZERO3;
      strap_s2_q  <= `SCS_ZERO3;
    end else begin
      duplex_s1_q <= {phy_duplex_half, phy_rate_10m, phy_link_up};
      duplex_s2_q <= duplex_s1_q;
      strap_s1_q  <= mode_strap_pins;
      strap_s2_q  <= strap_s1_q;
    end
  end

  // Flag synchroniser next value; stage two copies stage one.
  always_comb begin
    sy_d       = sy_q;
    sy_d.sync1 = {flash_busy_in, boot_running_in};
    sy_d.sync2 = sy_q.sync1;
  end

  // Flag synchroniser registers.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sy_q <= '0;
    end else begin
      sy_q <= sy_d;
    end
  end

  assign flash_busy_flag  = sy_q.sync2[1];
  assign boot_active_flag = sy_q.sync2[0];

  // ----------------------------------------------------------------
  // Read views
  // ----------------------------------------------------------------
  // Live PHY status in bits 2..0; upper bits always read zero.
  assign phy_state_reg = {`SCS_ZERO5, duplex_s2_q};

  // Writable fields come from storage, the two low flags are live.
  assign chip_config_reg = {st_q.cfg[7:3], 1'b0,
                            flash_busy_flag,
                            boot_active_flag};

  // ----------------------------------------------------------------
  // Register writes and read mux
  // ----------------------------------------------------------------
  // Writes to the status and counter offsets fall to the default
  // arm and change nothing. Read data is captured on the strobe and
  // held until the next read, so the core sees a stable byte.
  always_comb begin
    st_d = st_q;
    if (wr_en) begin
      unique case (addr)
        `SCS_OFF_PHY_SETUP: st_d.setup = wdata & `SCS_SETUP_WMASK;
        `SCS_OFF_CHIP_CFG:  st_d.cfg   = wdata & `SCS_CFG_WMASK;
        `SCS_OFF_LDR_ID:    st_d.ldr_id        = wdata;
        `SCS_OFF_LDR_AL:    st_d.ldr_addr[7:0] = wdata;
        `SCS_OFF_LDR_AH:    st_d.ldr_addr[15:8] = wdata;
        `SCS_OFF_LDR_DATA:  st_d.ldr_data      = wdata;
        `SCS_OFF_STR_BK:    st_d.str_bk        = wdata;
        `SCS_OFF_PX0_BK:    st_d.px0_bk        = wdata;
        `SCS_OFF_PX1_BK:    st_d.px1_bk        = wdata;
        `SCS_OFF_PSEL_BK:   st_d.psel_bk       = wdata;
        `SCS_OFF_RAMB_L:    st_d.ram_base[7:0]  = wdata;
        `SCS_OFF_RAMB_H:    st_d.ram_base[15:8] = wdata;
        `SCS_OFF_RAME_L:    st_d.ram_end[7:0]   = wdata;
        `SCS_OFF_RAME_H:    st_d.ram_end[15:8]  = wdata;
        default:            st_d.setup = st_q.setup;
      endcase
    end
    if (rd_en) begin
      unique case (addr)
        `SCS_OFF_CNT0:      st_d.rdata = cycle_counter[7:0];
        `SCS_OFF_CNT1:      st_d.rdata = cycle_counter[15:8];
        `SCS_OFF_CNT2:      st_d.rdata = cycle_counter[23:16];
        `SCS_OFF_CNT3:      st_d.rdata = cycle_counter[31:24];
        `SCS_OFF_PHY_STATE: st_d.rdata = phy_state_reg;
        `SCS_OFF_PHY_SETUP: st_d.rdata = st_q.setup;
        `SCS_OFF_CHIP_CFG:  st_d.rdata = chip_config_reg;
        `SCS_OFF_LDR_ID:    st_d.rdata = st_q.ldr_id;
        `SCS_OFF_LDR_AL:    st_d.rdata = st_q.ldr_addr[7:0];
        `SCS_OFF_LDR_AH:    st_d.rdata = st_q.ldr_addr[15:8];
        `SCS_OFF_LDR_DATA:  st_d.rdata = st_q.ldr_data;
        `SCS_OFF_STR_BK:    st_d.rdata = st_q.str_bk;
        `SCS_OFF_PX0_BK:    st_d.rdata = st_q.px0_bk;
        `SCS_OFF_PX1_BK:    st_d.rdata = st_q.px1_bk;
        `SCS_OFF_PSEL_BK:   st_d.rdata = st_q.psel_bk;
        `SCS_OFF_RAMB_L:    st_d.rdata = st_q.ram_base[7:0];
        `SCS_OFF_RAMB_H:    st_d.rdata = st_q.ram_base[15:8];
        `SCS_OFF_RAME_L:    st_d.rdata = st_q.ram_end[7:0];
        `SCS_OFF_RAME_H:    st_d.rdata = st_q.ram_end[15:8];
        default:            st_d.rdata = `SCS_RST_BYTE;
      endcase
    end
  end

  // Register the whole bank; reset gives all-zero contents.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  // The PHY reset bit is a plain level: hardware never clears it, so
  // the PHY stays in reset until software writes it back to zero.
  assign phy_reset_out  = st_q.setup[`SCS_SETUP_RST_BIT];
  assign phy_power_down = st_q.setup[`SCS_SETUP_SLEEP_BIT];

  // Register code has the strap encoding and replaces it only when
  // the override bit is set; otherwise the synchronised straps rule.
  assign phy_opmode = st_q.setup[`SCS_SETUP_OVR_BIT] ? st_q.setup[2:0]
                                                     : strap_s2_q;

  assign reboot_after_load = st_q.cfg[`SCS_CFG_RB_BIT];
  assign loader_enable     = ~st_q.cfg[`SCS_CFG_LDIS_BIT];
  assign offchip_store_mode = st_q.cfg[`SCS_CFG_EM_HI:`SCS_CFG_EM_LO];

  // Entry range access opens only with reboot set and a target in
  // the top nine bytes of the code space.
  assign entry_access_en = st_q.cfg[`SCS_CFG_RB_BIT]
                         & (loader_target >= `SCS_ENTRY_LO);

  assign rdata              = st_q.rdata;
  assign stretch_cfg_backup = st_q.str_bk;
  assign ptr_ext0_backup    = st_q.px0_bk;
  assign ptr_ext1_backup    = st_q.px1_bk;
  assign ptr_select_backup  = st_q.psel_bk;
  assign ram_base_reg       = st_q.ram_base;
  assign ram_end_reg        = st_q.ram_end;
  assign loader_ident_reg   = st_q.ldr_id;
  assign loader_addr_reg    = st_q.ldr_addr;
  assign loader_data_reg    = st_q.ldr_data;

endmodule : scs_regs

//--- scs_regs_map.svh
// Register offsets, field positions and reset values of the system configuration bank.
// Assumes an 8-bit special-register port with byte addresses 0x00 to 0xff.
`ifndef SCS_REGS_MAP_SVH
`define SCS_REGS_MAP_SVH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define SCS_OFF_CNT0      8'hdc
`define SCS_OFF_CNT1      8'hdd
`define SCS_OFF_CNT2      8'hde
`define SCS_OFF_CNT3      8'hdf
`define SCS_OFF_PHY_STATE 8'hef
`define SCS_OFF_LDR_ID    8'hf1
`define SCS_OFF_LDR_AL    8'hf2
`define SCS_OFF_LDR_AH    8'hf3
`define SCS_OFF_LDR_DATA  8'hf4
`define SCS_OFF_STR_BK    8'hf5
`define SCS_OFF_PX0_BK    8'hf6
`define SCS_OFF_PX1_BK    8'hf7
`define SCS_OFF_PSEL_BK   8'hf9
`define SCS_OFF_RAMB_L    8'hfa
`define SCS_OFF_RAMB_H    8'hfb
`define SCS_OFF_RAME_L    8'hfc
`define SCS_OFF_RAME_H    8'hfd
`define SCS_OFF_PHY_SETUP 8'hfe
`define SCS_OFF_CHIP_CFG  8'hff

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define SCS_SETUP_RST_BIT   5
`define SCS_SETUP_SLEEP_BIT 4
`define SCS_SETUP_OVR_BIT   3
`define SCS_SETUP_WMASK     8'h3f
`define SCS_CFG_RB_BIT      7
`define SCS_CFG_LDIS_BIT    6
`define SCS_CFG_EM_HI       5
`define SCS_CFG_EM_LO       3
`define SCS_CFG_WMASK       8'hf8
`define SCS_RST_BYTE        8'h00
`define SCS_RST_WORD        16'h0000
`define SCS_RST_CNT         32'h0000_0000
`define SCS_CNT_STEP        32'h0000_0001
`define SCS_ZERO3           3'h0
`define SCS_ZERO5           5'h00
`define SCS_ZERO6           6'h00
`define SCS_ENTRY_LO        16'hfff7

`endif

//--- scs_pkg.sv
// Types shared by the system configuration bank.
// Assumes scs_regs_map.svh is compiled alongside.
package scs_pkg;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  setup;
    logic [7:0]  cfg;
    logic [7:0]  ldr_id;
    logic [15:0] ldr_addr;
    logic [7:0]  ldr_data;
    logic [7:0]  str_bk;
    logic [7:0]  px0_bk;
    logic [7:0]  px1_bk;
    logic [7:0]  psel_bk;
    logic [15:0] ram_base;
    logic [15:0] ram_end;
    logic [7:0]  rdata;
  } scs_state_t;

  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
  } scs_sync_t;

endpackage : scs_pkg

//--- scs_cycle_counter.sv
// Free-running 32-bit core clock cycle counter.
// Assumes one core clock and an asynchronous active-high reset.
`timescale 1ns/1ns
`include "scs_regs_map.svh"

module scs_cycle_counter (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  output logic [31:0]      count
);

  typedef struct packed {
    logic [31:0] cnt;
  } scs_cnt_t;

  scs_cnt_t st_q;
  scs_cnt_t st_d;

  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  // Plain add; the carry out is dropped so the count wraps silently.
  always_comb begin
    st_d     = st_q;
    st_d.cnt = st_q.cnt + `SCS_CNT_STEP;
  end

  // Register the count; reset clears it.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q.cnt <= `SCS_RST_CNT;
    end else begin
      st_q <= st_d;
    end
  end

  assign count = st_q.cnt;

endmodule : scs_cycle_counter

//--- scs_regs_properties.sv
// Concurrent checks on the system configuration bank ports.
// Assumes rdata and control outputs update on the edge taking the strobe.
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Checker
// ----------------------------------------------------------------
module scs_regs_properties (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  addr,
  input wire logic        wr_en,
  input wire logic [7:0]  wdata,
  input wire logic        rd_en,
  input wire logic [7:0]  rdata,
  input wire logic [15:0] loader_target,
  input wire logic        phy_power_down,
  input wire logic [2:0]  phy_opmode,
  input wire logic        reboot_after_load,
  input wire logic        loader_enable,
  input wire logic [2:0]  offchip_store_mode,
  input wire logic        entry_access_en
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_phy_hi; rd_en && addr == 8'hef |=> rdata[7:3] == 5'h00; endproperty
  a_phy_hi: assert property (p_phy_hi) else $error("phy state upper bits set");
  property p_sleep; wr_en && addr == 8'hfe |=> phy_power_down == $past(wdata[4]); endproperty
  a_sleep: assert property (p_sleep) else $error("sleep control wrong");
  property p_ovr; wr_en && addr == 8'hfe && wdata[3] |=> phy_opmode == $past(wdata[2:0]);
  endproperty
  a_ovr: assert property (p_ovr) else $error("mode code not used");
  property p_reboot; wr_en && addr == 8'hff |=> reboot_after_load == $past(wdata[7]); endproperty
  a_reboot: assert property (p_reboot) else $error("reboot bit wrong");
  property p_ldis; wr_en && addr == 8'hff |=> loader_enable != $past(wdata[6]); endproperty
  a_ldis: assert property (p_ldis) else $error("loader enable wrong");
  property p_em; wr_en && addr == 8'hff |=> offchip_store_mode == $past(wdata[5:3]); endproperty
  a_em: assert property (p_em) else $error("offchip mode wrong");
  property p_cnt; rd_en && addr == 8'hdc ##1 rd_en && addr == 8'hdc
    |=> rdata == $past(rdata) + 8'h01; endproperty
  a_cnt: assert property (p_cnt) else $error("counter step wrong");
  property p_entry; reboot_after_load && loader_target >= 16'hfff7 |-> entry_access_en;
  endproperty
  a_entry: assert property (p_entry) else $error("entry range closed");
endmodule : scs_regs_properties

bind scs_regs scs_regs_properties i_chk (.clk(clk), .sys_rst(sys_rst), .addr(addr),
  .wr_en(wr_en), .wdata(wdata), .rd_en(rd_en), .rdata(rdata), .loader_target(loader_target),
  .phy_power_down(phy_power_down), .phy_opmode(phy_opmode),
  .reboot_after_load(reboot_after_load), .loader_enable(loader_enable),
  .offchip_store_mode(offchip_store_mode), .entry_access_en(entry_access_en));

//--- system_config_status_sfrs_test.sv
// Self-checking bench for the system configuration bank.
// Assumes scs_regs and its checker are compiled before this file.
`timescale 1ns/1ns
module system_config_status_sfrs_test;
  logic        clk = 1'b0, sys_rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  logic        phy_duplex_half = 1'b0, phy_rate_10m = 1'b0, phy_link_up = 1'b0;
  logic        flash_busy_in = 1'b1, boot_running_in = 1'b1;
  logic        phy_reset_out, phy_power_down, reboot_after_load, loader_enable;
  logic        entry_access_en;
  logic [2:0]  mode_strap_pins = 3'h0, phy_opmode, offchip_store_mode;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, stretch_cfg_backup, ptr_ext0_backup;
  logic [7:0]  ptr_ext1_backup, ptr_select_backup, loader_ident_reg, loader_data_reg, d;
  logic [15:0] loader_target = 16'h0000, ram_base_reg, ram_end_reg, loader_addr_reg;
  logic [31:0] seed = 32'h4;
  logic [7:0]  mem [256] = '{default: 8'h00};
  int          failures = 0, n_checks = 0, cyc = 0, ticks = 0;

  scs_regs i_dut (
    .clk (clk), .sys_rst (sys_rst), .addr (addr), .wr_en (wr_en), .wdata (wdata),
    .rd_en (rd_en), .rdata (rdata), .phy_duplex_half (phy_duplex_half),
    .phy_rate_10m (phy_rate_10m), .phy_link_up (phy_link_up),
    .mode_strap_pins (mode_strap_pins), .flash_busy_in (flash_busy_in),
    .boot_running_in (boot_running_in), .loader_target (loader_target),
    .phy_reset_out (phy_reset_out), .phy_power_down (phy_power_down),
    .phy_opmode (phy_opmode), .reboot_after_load (reboot_after_load),
    .loader_enable (loader_enable), .offchip_store_mode (offchip_store_mode),
    .entry_access_en (entry_access_en), .stretch_cfg_backup (stretch_cfg_backup),
    .ptr_ext0_backup (ptr_ext0_backup), .ptr_ext1_backup (ptr_ext1_backup),
    .ptr_select_backup (ptr_select_backup), .ram_base_reg (ram_base_reg),
    .ram_end_reg (ram_end_reg), .loader_ident_reg (loader_ident_reg),
    .loader_addr_reg (loader_addr_reg), .loader_data_reg (loader_data_reg)
  );

  // Clock, model of the counter and a hang limit well above the run length.
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= sys_rst ? 0 : cyc + 1;
    ticks <= ticks + 1;
    if (ticks == 4000) begin
      failures++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  // Expected read value; c is the counter value at the sampling edge.
  function automatic logic [7:0] exp_rd(input logic [7:0] a, input logic [31:0] c);
    if (a >= 8'hdc && a <= 8'hdf) return 8'(c >> (8 * (a - 8'hdc)));
    if (a == 8'hef) return {5'h00, phy_duplex_half, phy_rate_10m, phy_link_up};
    if (a == 8'hff) return {mem[a][7:3], 1'b0, flash_busy_in, boot_running_in};
    return mem[a];
  endfunction : exp_rd

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Writes at a falling edge; reserved setup bits are always sent as zero.
  // One idle cycle follows each write so the strobe never changes twice at once.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    if (a == 8'hfe) v = v & 8'h3f;
    addr = a;
    wdata = v;
    wr_en = 1'b1;
    if (a == 8'hfe || (a >= 8'hf1 && a <= 8'hfd && a != 8'hf8)) mem[a] = v;
    if (a == 8'hff) mem[a] = v & 8'hf8;
    @(negedge clk);
    wr_en = 1'b0;
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic [31:0] c;
    c = cyc;
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    @(negedge clk);
    chk("rdata", rdata, exp_rd(a, c));
  endtask : rd

  task automatic sweep(input string t);
    for (int a = 8'hdc; a < 256; a++) rd(8'(a));
    rd(8'h00);
    $display("test %s done", t);
  endtask : sweep

  task automatic conclude;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    chk("ldr_en", loader_enable, 1'b1);
    sweep("reset");
    for (int a = 8'hdc; a < 256; a++) wr(8'(a), rnd());
    sweep("random writes");
    chk("bk", {stretch_cfg_backup, ptr_ext0_backup, ptr_ext1_backup, ptr_select_backup},
        {mem[8'hf5], mem[8'hf6], mem[8'hf7], mem[8'hf9]});
    chk("ram", {ram_base_reg, ram_end_reg}, {mem[8'hfb], mem[8'hfa], mem[8'hfd], mem[8'hfc]});
    chk("ldr", {loader_ident_reg, loader_addr_reg, loader_data_reg},
        {mem[8'hf1], mem[8'hf3], mem[8'hf2], mem[8'hf4]});
    for (int m = 0; m < 8; m++) begin
      mode_strap_pins = 3'(m);
      wr(8'hfe, 8'h00);
      repeat (2) @(negedge clk);
      chk("strap", phy_opmode, m);
      chk("phy_on", {phy_reset_out, phy_power_down}, 2'b00);
      wr(8'hfe, 8'h38 | 8'(7 - m));
      chk("opmode", phy_opmode, 7 - m);
      chk("phy_off", {phy_reset_out, phy_power_down}, 2'b11);
    end
    $display("test modes done");
    for (int e = 0; e < 8; e++) begin
      d = 8'(e << 3) | (e[0] ? 8'hc0 : 8'h00);
      loader_target = e[1] ? 16'hfff7 : 16'hfff6;
      wr(8'hff, d);
      chk("cfg", {reboot_after_load, loader_enable, offchip_store_mode},
          {d[7], ~d[6], d[5:3]});
      chk("entry", entry_access_en, d[7] & e[1]);
    end
    $display("test config done");
    for (int i = 0; i < 6; i++) begin
      d = rnd();
      {phy_duplex_half, phy_rate_10m, phy_link_up, flash_busy_in, boot_running_in} = d[4:0];
      repeat (3) @(negedge clk);
      rd(8'hef);
      rd(8'hff);
    end
    addr = 8'hdc;
    rd_en = 1'b1;
    repeat (2) @(negedge clk);
    rd_en = 1'b0;
    @(negedge clk);
    rd(8'hdc);
    $display("test status done");
    conclude();
  end
endmodule : system_config_status_sfrs_test
